/* ccp_otc_pkg.sv */
package ccp_otc_pkg;
	// APB register byte offsets; each register sits in one aligned word.
	localparam logic [7:0] ADDR_OE_GATING = 8'h00;
	localparam logic [7:0] ADDR_DEADBAND = 8'h04;
	localparam logic [7:0] ADDR_MODE_SHUTDOWN = 8'h08;
	localparam logic [7:0] ADDR_TRIG_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_WIP_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

	// Writable bit masks; any bit outside a mask reads zero.
	localparam logic [15:0] MASK_OE_GATING = 16'hBFDF;
	localparam logic [15:0] MASK_DEADBAND = 16'h003F;
	localparam logic [15:0] MASK_MODE_FULL = 16'hF73F;
	localparam logic [15:0] MASK_MODE_SINGLE = 16'hF000;
	localparam logic [2:0] MASK_IRQ = 3'h7;

	// Reset values of every register.
	localparam logic [15:0] RESET_REG16 = 16'h0000;
	localparam logic [2:0] RESET_IRQ = 3'h0;

	// Field positions in the output-enable gating register.
	localparam int OE_SYNC_BIT = 15;
	localparam int OE_EN_LSB = 8;
	localparam int OE_PIN_COUNT = 6;

	// Field positions in the dead-band register.
	localparam int DB_LSB = 0;
	localparam int DB_WIDTH = 6;

	// Field positions in the output-mode and shutdown register.
	localparam int HOLD_TRIG_BIT = 15;
	localparam int PULSE_EXT_LSB = 12;
	localparam int PULSE_EXT_WIDTH = 3;
	localparam int POL_A_BIT = 5;
	localparam int POL_B_BIT = 4;
	localparam int PSS_A_LSB = 2;
	localparam int PSS_B_LSB = 0;

	// Field positions in the trigger status register.
	localparam int TRIG_FLAG_BIT = 7;
	localparam int TRIG_SET_BIT = 6;
	localparam int TRIG_CANCEL_BIT = 5;

	// Number of buffered-update pending flags.
	localparam int WIP_COUNT = 5;

	// Interrupt status bit positions.
	localparam int IRQ_TRIGGERED = 0;
	localparam int IRQ_CANCELLED = 1;
	localparam int IRQ_ONESHOT_DONE = 2;

	// Shutdown state codes for a pin pair.
	localparam logic [1:0] PSS_ACTIVE = 2'h3;
	localparam logic [1:0] PSS_INACTIVE = 2'h2;
endpackage : ccp_otc_pkg

/* ccp_deadband.sv */
`timescale 1ns/1ps
// Turns one raw drive level into a complementary pair with a programmable gap.
module ccp_deadband
	import ccp_otc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic raw_level,
	input wire logic [DB_WIDTH-1:0] deadband_periods,
	output logic out_a,
	output logic out_b
);
	// Cycles the raw level has stood still since its last change.
	logic [DB_WIDTH-1:0] stable_count;
	// Raw level seen on the previous edge.
	logic raw_prev;

	// Count how long the raw level has been steady, saturating at the top.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stable_count <= '0;
			raw_prev <= 1'b0;
		end else begin
			raw_prev <= raw_level;
			if (raw_level != raw_prev) begin
				stable_count <= '0;
			end else if (stable_count != {DB_WIDTH{1'b1}}) begin
				stable_count <= stable_count + 1'b1;
			end
		end
	end

	// Each side turns on only after the gap; both turn off at once.
	// This keeps the pair from ever being active together.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_a <= 1'b0;
			out_b <= 1'b0;
		end else if (deadband_periods == '0) begin
			// A zero gap bypasses the delay entirely.
			out_a <= raw_level;
			out_b <= !raw_level;
		end else begin
			// The gap counts whole clock periods after the change.
			out_a <= raw_level && (raw_level == raw_prev)
				&& (stable_count >= deadband_periods - 1'b1);
			out_b <= !raw_level && (raw_level == raw_prev)
				&& (stable_count >= deadband_periods - 1'b1);
		end
	end
endmodule : ccp_deadband

/* ccp_output_trigger_control.sv */
`timescale 1ns/1ps
// Operation
// - Output enables apply at rollover when synced.
// - Nonzero dead-band inserts N gap periods.
// - Zero dead-band disables the gap logic.
// - Dead-band register only in multi-output variant.
// - Pulse extend K gives K+1 periods.
// - Triggered flag shows running, else reset.
// - Cancel strobe clears trigger, reads zero.
// - Mode, polarity, shutdown only in multi-output.
// - Hold enabled pins undriven until triggered, only while trigger operation is on.
module ccp_output_trigger_control
	import ccp_otc_pkg::*;
#(
	parameter bit MULTI_OUTPUT_VARIANT = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic time_base_rollover,
	input wire logic trigger_operation_enable,
	input wire logic trigger_event,
	input wire logic oneshot_event,
	input wire logic compare_level,
	input wire logic shutdown_active,
	input wire logic [WIP_COUNT-1:0] update_pending,
	output logic [OE_PIN_COUNT-1:0] pin_output_enable_n,
	output logic pwm_out_a,
	output logic pwm_out_b,
	output logic timer_run,
	output logic oneshot_active,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////////
	// Register storage.

	// Output-enable gating control as written by software.
	logic [15:0] output_enable_gating_control;
	// Dead-band control; stays zero in the single-output variant.
	logic [15:0] deadband_control;
	// Output mode, hold, pulse extend, polarity and shutdown state.
	logic [15:0] output_mode_shutdown_control;
	// Sticky interrupt status and its mask.
	logic [2:0] irq_status;
	logic [2:0] irq_mask;
	// Pin enables actually in force on the pins.
	logic [OE_PIN_COUNT-1:0] active_output_enable;
	// Trigger state of the timer.
	logic timer_triggered_flag;
	// Captured pending flags from the datapath.
	logic [WIP_COUNT-1:0] pending_seen;
	// Remaining time-base periods of the one-shot pulse, less one.
	logic [PULSE_EXT_WIDTH-1:0] oneshot_left;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	// A write or a read completes in the access phase when pready is high.
	logic bus_write;
	logic bus_setup;
	assign bus_write = psel && penable && pwrite && pready;
	assign bus_setup = psel && !penable;

	// Compares a bus address with the offset of one register.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		hit = (addr == target);
	endfunction : hit

	// Writable mask of the mode register depends on the variant.
	logic [15:0] mode_mask;
	assign mode_mask = MULTI_OUTPUT_VARIANT ? MASK_MODE_FULL : MASK_MODE_SINGLE;

	// Software strobes in the trigger status register.
	logic sw_trigger_set;
	logic sw_trigger_cancel;
	assign sw_trigger_set = bus_write && hit(paddr, ADDR_TRIG_STATUS)
		&& pwdata[TRIG_SET_BIT] && trigger_operation_enable;
	assign sw_trigger_cancel = bus_write && hit(paddr, ADDR_TRIG_STATUS)
		&& pwdata[TRIG_CANCEL_BIT] && trigger_operation_enable;

	// Named fields of the stored controls.
	logic oe_sync;
	logic hold_outputs_until_trigger;
	logic [PULSE_EXT_WIDTH-1:0] pulse_extend_count;
	logic [DB_WIDTH-1:0] deadband_periods;
	assign oe_sync = output_enable_gating_control[OE_SYNC_BIT];
	assign hold_outputs_until_trigger = output_mode_shutdown_control[HOLD_TRIG_BIT];
	assign pulse_extend_count =
		output_mode_shutdown_control[PULSE_EXT_LSB +: PULSE_EXT_WIDTH];
	assign deadband_periods = deadband_control[DB_LSB +: DB_WIDTH];

	////////////////////////////////////////////////////////////////////////////////
	// APB answer: zero wait states, read data set up during the setup cycle.

	// Read mux of every mapped register; unmapped reads give zero.
	logic [15:0] read_value;
	logic read_mapped;
	always_comb begin
		read_value = 16'h0000;
		read_mapped = 1'b1;
		unique case (paddr)
			ADDR_OE_GATING: read_value = output_enable_gating_control;
			ADDR_DEADBAND: read_value = deadband_control;
			ADDR_MODE_SHUTDOWN: read_value = output_mode_shutdown_control;
			// Set and cancel strobes always read back as zero.
			ADDR_TRIG_STATUS: read_value = {8'h00, timer_triggered_flag, 7'h00};
			ADDR_WIP_STATUS: read_value = {11'h0, pending_seen};
			ADDR_IRQ_STATUS: read_value = {13'h0, irq_status};
			ADDR_IRQ_MASK: read_value = {13'h0, irq_mask};
			default: read_mapped = 1'b0;
		endcase
	end

	// The answer is registered in the setup cycle, so pready stands high
	// in the first access cycle and the bus never waits.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= bus_setup;
			pslverr <= bus_setup && !read_mapped;
			prdata <= bus_setup && !pwrite ? {16'h0000, read_value} : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register writes.

	// Only implemented bits take a write; the rest stay zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_enable_gating_control <= RESET_REG16;
			deadband_control <= RESET_REG16;
			output_mode_shutdown_control <= RESET_REG16;
			irq_mask <= RESET_IRQ;
		end else if (bus_write) begin
			if (hit(paddr, ADDR_OE_GATING)) begin
				output_enable_gating_control <= pwdata[15:0] & MASK_OE_GATING;
			end
			// The single-output variant has no dead-band storage at all.
			if (hit(paddr, ADDR_DEADBAND) && MULTI_OUTPUT_VARIANT) begin
				deadband_control <= pwdata[15:0] & MASK_DEADBAND;
			end
			if (hit(paddr, ADDR_MODE_SHUTDOWN)) begin
				output_mode_shutdown_control <= pwdata[15:0] & mode_mask;
			end
			if (hit(paddr, ADDR_IRQ_MASK)) begin
				irq_mask <= pwdata[2:0] & MASK_IRQ;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output-enable update timing.

	// With sync set the new enables wait for the next rollover; a pin
	// therefore never takes a written enable in the middle of a period.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_output_enable <= '0;
		end else if (!oe_sync || time_base_rollover) begin
			active_output_enable <=
				output_enable_gating_control[OE_EN_LSB +: OE_PIN_COUNT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trigger state.

	// A hardware or software trigger wins over a cancel in the same cycle.
	// Turning trigger operation off returns the flag to zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_triggered_flag <= 1'b0;
		end else if (!trigger_operation_enable) begin
			timer_triggered_flag <= 1'b0;
		end else if (trigger_event || sw_trigger_set) begin
			timer_triggered_flag <= 1'b1;
		end else if (sw_trigger_cancel) begin
			timer_triggered_flag <= 1'b0;
		end
	end

	// The timer runs freely without trigger operation, else only once triggered.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_run <= 1'b0;
		end else begin
			timer_run <= !trigger_operation_enable || timer_triggered_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// One-shot pulse extension.

	// The pulse starts on the event and lasts K+1 time-base periods,
	// counted in rollovers; a new event while active restarts the count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oneshot_active <= 1'b0;
			oneshot_left <= '0;
		end else if (oneshot_event) begin
			oneshot_active <= 1'b1;
			oneshot_left <= pulse_extend_count;
		end else if (oneshot_active && time_base_rollover) begin
			if (oneshot_left == '0) begin
				oneshot_active <= 1'b0;
			end else begin
				oneshot_left <= oneshot_left - 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Buffered-update pending flags.

	// Mirrors the datapath so software sees a steady registered value.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_seen <= '0;
		end else begin
			pending_seen <= update_pending;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Complementary outputs with dead band, polarity and shutdown.

	// Complementary pair before polarity and shutdown.
	logic pair_a;
	logic pair_b;

	ccp_deadband u_deadband (
		.pclk(pclk),
		.presetn(presetn),
		.raw_level(compare_level),
		.deadband_periods(deadband_periods),
		.out_a(pair_a),
		.out_b(pair_b)
	);

	// Applies a shutdown state code to one active-high level.
	function automatic logic shut_level(input logic level, input logic [1:0] pss,
		input logic shut);
		if (!shut) begin
			shut_level = level;
		end else begin
			shut_level = (pss == PSS_ACTIVE);
		end
	endfunction : shut_level

	// Polarity inverts the active level after the shutdown choice.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_out_a <= 1'b0;
			pwm_out_b <= 1'b0;
		end else begin
			pwm_out_a <= shut_level(pair_a,
				output_mode_shutdown_control[PSS_A_LSB +: 2], shutdown_active)
				^ output_mode_shutdown_control[POL_A_BIT];
			pwm_out_b <= shut_level(pair_b,
				output_mode_shutdown_control[PSS_B_LSB +: 2], shutdown_active)
				^ output_mode_shutdown_control[POL_B_BIT];
		end
	end

	// A floating shutdown state on side A lets every pin go while shut down.
	logic shut_release;
	assign shut_release = shutdown_active
		&& !output_mode_shutdown_control[PSS_A_LSB + 1];

	// A pin is driven when enabled, not held for a trigger and not released.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_output_enable_n <= {OE_PIN_COUNT{1'b1}};
		end else if (hold_outputs_until_trigger && trigger_operation_enable
			&& !timer_triggered_flag) begin
			pin_output_enable_n <= {OE_PIN_COUNT{1'b1}};
		end else if (shut_release) begin
			pin_output_enable_n <= {OE_PIN_COUNT{1'b1}};
		end else begin
			pin_output_enable_n <= ~active_output_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts.

	// Events of this block, one cycle each.
	logic trigger_rise;
	logic oneshot_end;
	logic [2:0] irq_events;
	assign trigger_rise = trigger_operation_enable && !timer_triggered_flag
		&& (trigger_event || sw_trigger_set);
	assign oneshot_end = oneshot_active && time_base_rollover && !oneshot_event
		&& (oneshot_left == '0);
	assign irq_events = {oneshot_end, sw_trigger_cancel && timer_triggered_flag
		&& !trigger_event && !sw_trigger_set, trigger_rise};

	// Write one to clear; an event in the same cycle keeps its bit set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= RESET_IRQ;
		end else begin
			if (bus_write && hit(paddr, ADDR_IRQ_STATUS)) begin
				irq_status <= (irq_status & ~pwdata[2:0]) | irq_events;
			end else begin
				irq_status <= irq_status | irq_events;
			end
		end
	end

	// Level interrupt, high while any unmasked bit is set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end
endmodule : ccp_output_trigger_control

/* ccp_output_trigger_control_asserts.sv */
`timescale 1ns/1ps
// Watches the bus answer, the trigger state and the one-shot output of the block.
module ccp_otc_asserts
	import ccp_otc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic time_base_rollover,
	input wire logic trigger_operation_enable,
	input wire logic trigger_event,
	input wire logic oneshot_event,
	input wire logic compare_level,
	input wire logic shutdown_active,
	input wire logic [WIP_COUNT-1:0] update_pending,
	input wire logic [OE_PIN_COUNT-1:0] pin_output_enable_n,
	input wire logic pwm_out_a,
	input wire logic pwm_out_b,
	input wire logic timer_run,
	input wire logic oneshot_active,
	input wire logic irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////
	// Every setup cycle is answered in the very next cycle.
	property p_ready_after_setup;
		psel && !penable |=> pready;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready late");
	// An error answer never comes without pready.
	property p_err_with_ready;
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("stray pslverr");
	// Read data stays zero outside the answer cycle, so stale data cannot leak.
	property p_idle_zero;
		!pready |-> prdata == 32'h00000000;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("prdata not zero");
	// With trigger operation off the timer simply runs.
	// The sampled reset level keeps the release edge itself out, since the
	// design is still in reset at that edge.
	property p_run_untriggered;
		presetn && !trigger_operation_enable |=> timer_run;
	endproperty
	a_run_untriggered: assert property (p_run_untriggered) else $error("timer held");
	// A trigger starts the timer two edges later.
	property p_run_after_trigger;
		trigger_operation_enable && trigger_event ##1 trigger_operation_enable |=> timer_run;
	endproperty
	a_run_after_trigger: assert property (p_run_after_trigger) else $error("no run");
	// A cancel write stops the timer when no trigger competes with it.
	property p_cancel_stops;
		psel && penable && pready && pwrite && paddr == ADDR_TRIG_STATUS
		&& pwdata[TRIG_CANCEL_BIT] && !pwdata[TRIG_SET_BIT] && trigger_operation_enable
		&& !trigger_event ##1 trigger_operation_enable && !trigger_event |=> !timer_run;
	endproperty
	a_cancel_stops: assert property (p_cancel_stops) else $error("cancel ignored");
	// A one-shot event opens the pulse at once.
	property p_oneshot_start;
		oneshot_event |=> oneshot_active;
	endproperty
	a_oneshot_start: assert property (p_oneshot_start) else $error("no pulse");
	// The pulse only ends on a time-base rollover.
	property p_oneshot_end;
		$fell(oneshot_active) |-> $past(time_base_rollover);
	endproperty
	a_oneshot_end: assert property (p_oneshot_end) else $error("pulse end off");
	c_trigger: cover property (trigger_operation_enable && trigger_event);
	c_oneshot: cover property ($fell(oneshot_active));
	c_error: cover property (pslverr);
endmodule : ccp_otc_asserts

bind ccp_output_trigger_control ccp_otc_asserts u_otc_asserts (.*);

/* test_ccp_output_trigger_control.sv */
`timescale 1ns/1ps
// Bench for register map, trigger, output gating, one-shot and dead band.
module test_ccp_output_trigger_control
	import ccp_otc_pkg::*;
;
	// One table row: address, write data, pending inputs, read back, error.
	typedef struct {
		logic [7:0] a;
		logic [15:0] d;
		logic [4:0] p;
		logic [31:0] x;
		logic e;
	} reg_row_t;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic pready, pslverr, er, pwm_out_a, pwm_out_b, timer_run, oneshot_active, irq;
	logic time_base_rollover = 1'b0, trigger_operation_enable = 1'b0;
	logic trigger_event = 1'b0, oneshot_event = 1'b0, compare_level = 1'b0;
	logic shutdown_active = 1'b0; // Raised only in the shutdown test.
	logic [WIP_COUNT-1:0] update_pending = 5'h00;
	logic [OE_PIN_COUNT-1:0] pin_output_enable_n;
	int error_cnt = 0, check_count = 0, n;
	int db_list [4] = '{0, 1, 5, 63};
	logic [7:0] zero_addr [7] = '{ADDR_OE_GATING, ADDR_DEADBAND, ADDR_MODE_SHUTDOWN,
		ADDR_TRIG_STATUS, ADDR_WIP_STATUS, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
	// Writable masks show in the read back; the last row is an unmapped word.
	reg_row_t rows [8] = '{'{ADDR_OE_GATING, 16'hFFFF, 5'h00, 32'h0000BFDF, 1'b0},
		'{ADDR_DEADBAND, 16'hFFFF, 5'h00, 32'h0000003F, 1'b0},
		'{ADDR_MODE_SHUTDOWN, 16'hFFFF, 5'h00, 32'h0000F73F, 1'b0},
		'{ADDR_IRQ_MASK, 16'hFFFF, 5'h00, 32'h00000007, 1'b0},
		'{ADDR_IRQ_MASK, 16'h0000, 5'h00, 32'h00000000, 1'b0},
		'{ADDR_WIP_STATUS, 16'hFFFF, 5'h15, 32'h00000015, 1'b0},
		'{ADDR_WIP_STATUS, 16'h0000, 5'h0A, 32'h0000000A, 1'b0},
		'{8'h1C, 16'hFFFF, 5'h00, 32'h00000000, 1'b1}};
	ccp_output_trigger_control #(.MULTI_OUTPUT_VARIANT(1'b1)) dut_u (.*);
	always #2 pclk = ~pclk;
	////////////////////////////////////////
	task automatic tick(input int c);
		repeat (c) @(posedge pclk);
	endtask : tick
	// One APB transfer; the request is held until pready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, d, rd, er);
	endtask : wr
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 16'h0000, rd, er);
		chk(nm, x, rd);
	endtask : rd_chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done
	////////////////////////////////////////
	// The whole run is about 700 cycles; the limit of 40000 is over fifty times that.
	initial begin
		tick(40000);
		error_cnt++;
		test_done();
	end
	initial begin
		tick(20);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			update_pending <= rows[i].p;
			wr(rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 16'h0000, rd, er);
			chk("table read", rows[i].x, rd);
			chk("table error", 32'(rows[i].e), 32'(er));
		end
		$display("register table done");
		wr(ADDR_MODE_SHUTDOWN, 16'h0000);
		wr(ADDR_OE_GATING, 16'h0000);
		trigger_operation_enable <= 1'b1;
		tick(3);
		#1;
		chk("run idle", 32'h0, 32'(timer_run));
		rd_chk("flag idle", ADDR_TRIG_STATUS, 32'h0);
		trigger_event <= 1'b1;
		tick(1);
		trigger_event <= 1'b0;
		tick(2);
		#1;
		chk("run on", 32'h1, 32'(timer_run));
		rd_chk("flag on", ADDR_TRIG_STATUS, 32'h80);
		wr(ADDR_TRIG_STATUS, 16'h0020);
		tick(2);
		#1;
		chk("run cancelled", 32'h0, 32'(timer_run));
		rd_chk("cancel reads zero", ADDR_TRIG_STATUS, 32'h0);
		wr(ADDR_TRIG_STATUS, 16'h0040);
		rd_chk("soft trigger", ADDR_TRIG_STATUS, 32'h80);
		rd_chk("irq status", ADDR_IRQ_STATUS, 32'h3);
		chk("irq masked", 32'h0, 32'(irq));
		wr(ADDR_IRQ_MASK, 16'h0003);
		tick(2);
		#1;
		chk("irq raised", 32'h1, 32'(irq));
		wr(ADDR_IRQ_STATUS, 16'h0003);
		tick(2);
		#1;
		chk("irq cleared", 32'h0, 32'(irq));
		$display("trigger test done");
		// Pins stay released until a trigger while holding is asked for.
		wr(ADDR_TRIG_STATUS, 16'h0020);
		wr(ADDR_OE_GATING, 16'h3F00);
		wr(ADDR_MODE_SHUTDOWN, 16'h8000);
		tick(3);
		#1;
		chk("pins held", 32'h3F, 32'(pin_output_enable_n));
		tick(1);
		trigger_event <= 1'b1;
		tick(1);
		trigger_event <= 1'b0;
		tick(3);
		#1;
		chk("pins driven", 32'h0, 32'(pin_output_enable_n));
		wr(ADDR_MODE_SHUTDOWN, 16'h0000);
		trigger_operation_enable <= 1'b0;
		wr(ADDR_OE_GATING, 16'h0100);
		tick(2);
		#1;
		chk("pins direct", 32'h3E, 32'(pin_output_enable_n));
		wr(ADDR_OE_GATING, 16'h8300);
		tick(4);
		#1;
		chk("pins wait rollover", 32'h3E, 32'(pin_output_enable_n));
		tick(1);
		time_base_rollover <= 1'b1;
		tick(1);
		time_base_rollover <= 1'b0;
		tick(1);
		#1;
		chk("pins at rollover", 32'h3C, 32'(pin_output_enable_n));
		$display("output gating test done");
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_MODE_SHUTDOWN, 16'(k << PULSE_EXT_LSB));
			oneshot_event <= 1'b1;
			tick(1);
			oneshot_event <= 1'b0;
			n = 0;
			tick(1);
			#1;
			while (oneshot_active === 1'b1 && n < 10) begin
				tick(1);
				time_base_rollover <= 1'b1;
				tick(1);
				time_base_rollover <= 1'b0;
				n++;
				#1;
			end
			chk("pulse periods", 32'(k + 1), 32'(n));
		end
		$display("one-shot test done");
		foreach (db_list[i]) begin
			wr(ADDR_DEADBAND, 16'(db_list[i]));
			compare_level <= 1'b0;
			tick(70);
			compare_level <= 1'b1;
			n = 0;
			while (pwm_out_a !== 1'b1 && n < 80) begin
				tick(1);
				#1;
				n++;
			end
			chk("dead band rise", 32'(2 + db_list[i]), 32'(n));
			chk("complement low", 32'h0, 32'(pwm_out_b));
		end
		$display("dead band test done");
		// Raw level is high here; polarity flips both sides of the pair.
		wr(ADDR_MODE_SHUTDOWN, 16'h0030);
		tick(2);
		#1;
		chk("polarity pair", 32'h1, 32'({pwm_out_a, pwm_out_b}));
		tick(1);
		shutdown_active <= 1'b1;
		// Side A forced inactive, side B forced active, pins stay driven.
		wr(ADDR_MODE_SHUTDOWN, 16'h000B);
		tick(2);
		#1;
		chk("shutdown pair", 32'h1, 32'({pwm_out_a, pwm_out_b}));
		chk("shutdown pins", 32'h3C, 32'(pin_output_enable_n));
		// A floating code for side A lets every pin go.
		wr(ADDR_MODE_SHUTDOWN, 16'h0000);
		tick(2);
		#1;
		chk("released pins", 32'h3F, 32'(pin_output_enable_n));
		tick(1);
		shutdown_active <= 1'b0;
		tick(2);
		#1;
		chk("resumed pair", 32'h2, 32'({pwm_out_a, pwm_out_b}));
		chk("resumed pins", 32'h3C, 32'(pin_output_enable_n));
		$display("shutdown test done");
		// A second reset in mid-run must clear every register again.
		tick(1);
		presetn <= 1'b0;
		update_pending <= 5'h00;
		tick(20);
		#1;
		chk("reset pins", 32'h3F, 32'(pin_output_enable_n));
		chk("reset irq", 32'h0, 32'(irq));
		tick(1);
		presetn <= 1'b1;
		foreach (zero_addr[i]) rd_chk("reset value", zero_addr[i], 32'h0);
		chk("run after reset", 32'h1, 32'(timer_run));
		$display("reset test done");
		test_done();
	end
endmodule : test_ccp_output_trigger_control
